// ### logic/dmx_exec.sv
// Purpose: decode and execute four data-move instructions over four quarter-phases
// Assumes: instruction word and memory read data come from logic on the same clock;
//          read data is valid by the end of the read quarter
// Notes:   one instruction cycle is four quarters of DMX_Q_DIV clocks each
// Notes on behaviour
// RULE_01: file move copies value, updates N and Z
// RULE_02: d=0 writes working register, d=1 writes file
// RULE_03: a=0 access bank, a=1 bank select register
// RULE_04: extended mode, a=0, f<=95 uses indexed offset
// RULE_05: file operand is 8 bits, whole bank
// RULE_06: file-to-file move is two words, 12-bit addresses
// RULE_07: working register may be source or destination
// RULE_08: stream never targets program counter or stack bytes
// RULE_09: two cycles, no flags, no dummy read
// RULE_10: bank load clears bits 7:4, flags unchanged
// RULE_11: literal to working register, one cycle, no flags
`timescale 1ns/1ps
`include "dmx_cfg.svh"
`default_nettype none
module dmx_exec
   import dmx_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         reset,
   // instruction stream
   input  wire logic         instr_valid,
   input  wire logic [15:0]  instr_word,
   // extended mode
   input  wire logic         ext_enable,
   input  wire logic [11:0]  index_base,
   // data memory
   input  wire logic [7:0]   mem_rdata,
   output var  dmx_mem_req_t mem_q,
   // core state
   output var  logic [7:0]   w_q,
   output var  logic [7:0]   bsr_q,
   output var  logic         flag_n_q,
   output var  logic         flag_z_q,
   output var  logic [1:0]   phase_q
);
   logic [2:0]  div_q;      // clocks within a quarter
   logic        qce;        // last clock of a quarter
   dmx_state_t  state_q;    // sequencer state
   dmx_op_t     op_q;       // instruction in flight
   logic        d_q;        // destination select
   logic [7:0]  lit_q;      // literal or file operand
   logic [11:0] dst_q;      // file-to-file destination
   logic [7:0]  data_q;     // value being moved
   logic        take;       // decode point of an instruction cycle

   assign qce  = (div_q == `DMX_Q_DIV - 3'd1);
   assign take = qce && (phase_q == `DMX_Q1);

   // effective address of an 8-bit file operand
   function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                             input logic ext, input logic [11:0] base,
                                             input logic [7:0] bank_select_register);
      file_addr = {`DMX_ACCESS_HI, f};
      if (a) begin
         file_addr = {bank_select_register[3:0], f};                          // [RULE_03] [RULE_05]
      end else if (f <= `DMX_ILO_MAX) begin
         // indexed offset only with the extended set
         file_addr = ext ? base + {4'h0, f} : {4'h0, f};     // [RULE_04]
      end
   endfunction

   // quarter divider and phase counter
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q   <= 3'h0;
         phase_q <= `DMX_Q1;
      end else if (qce) begin
         div_q   <= 3'h0;
         phase_q <= phase_q + 2'h1;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   // decode and sequencing
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= st_idle;
         op_q    <= op_none;
         d_q     <= 1'b0;
         lit_q   <= 8'h00;
         dst_q   <= 12'h000;
      end else if (take && state_q == st_idle) begin
         d_q   <= instr_word[`DMX_D_BIT];
         lit_q <= instr_word[7:0];
         op_q  <= op_none;
         if (instr_valid) begin
            if (instr_word[15:10] == `DMX_OPC_MOVE_FILE) begin
               op_q <= op_move_file;                         // [RULE_01]
            end else if (instr_word[15:12] == `DMX_PFX_FF_SRC) begin
               op_q    <= op_move_ff;                        // [RULE_06]
               state_q <= st_ff_first;
            end else if (instr_word[15:8] == `DMX_OPC_LOAD_BANK) begin
               op_q <= op_load_bank;
            end else if (instr_word[15:8] == `DMX_OPC_LOAD_W) begin
               op_q <= op_load_w;                            // [RULE_11]
            end
         end
      end else if (take && state_q == st_ff_second) begin
         // second word must carry the destination prefix, else drop the move
         if (instr_valid && instr_word[15:12] == `DMX_PFX_FF_DST) begin
            dst_q   <= instr_word[11:0];                     // [RULE_06]
            state_q <= st_ff_write;
         end else begin
            op_q    <= op_none;
            state_q <= st_idle;
         end
      end else if (qce && phase_q == `DMX_Q4) begin
         case (state_q)
            st_ff_first: state_q <= st_ff_second;            // [RULE_09]
            st_ff_write: begin
               state_q <= st_idle;
               op_q    <= op_none;
            end
            st_idle:     op_q <= op_none;
            default:     state_q <= st_idle;
         endcase
      end
   end

   // data memory requests: read in Q2, write in Q4
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mem_q <= '0;
      end else if (take && state_q == st_idle) begin
         mem_q.rd <= 1'b0;
         if (instr_valid && instr_word[15:10] == `DMX_OPC_MOVE_FILE) begin
            mem_q.rd   <= 1'b1;
            mem_q.addr <= file_addr(instr_word[7:0], instr_word[`DMX_A_BIT], ext_enable,
                                    index_base, bsr_q);
         end else if (instr_valid && instr_word[15:12] == `DMX_PFX_FF_SRC) begin
            // a working-register source needs no memory read
            mem_q.rd   <= (instr_word[11:0] != `DMX_W_ADDR); // [RULE_07]
            mem_q.addr <= instr_word[11:0];
         end
      end else if (qce && phase_q == `DMX_Q2) begin
         mem_q.rd <= 1'b0;
      end else if (qce && phase_q == `DMX_Q3) begin
         if (op_q == op_move_file && d_q) begin
            mem_q.wr    <= 1'b1;                             // [RULE_02]
            mem_q.wdata <= data_q;
         end else if (state_q == st_ff_write && dst_q != `DMX_W_ADDR) begin
            mem_q.wr    <= 1'b1;                             // [RULE_09]
            mem_q.addr  <= dst_q;
            mem_q.wdata <= data_q;
         end
      end else if (qce && phase_q == `DMX_Q4) begin
         mem_q.wr <= 1'b0;
      end
   end

   // capture the moved value at the end of the read quarter
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_q <= 8'h00;
      end else if (qce && phase_q == `DMX_Q2 &&
                   (op_q == op_move_file || state_q == st_ff_first)) begin
         data_q <= (op_q == op_move_ff && mem_q.addr == `DMX_W_ADDR) ? w_q : mem_rdata;
      end
   end

   // working register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         w_q <= `DMX_W_RST;
      end else if (qce && phase_q == `DMX_Q4) begin
         if (op_q == op_move_file && !d_q) begin
            w_q <= data_q;                                   // [RULE_02]
         end else if (op_q == op_load_w) begin
            w_q <= lit_q;                                    // [RULE_11]
         end else if (state_q == st_ff_write && dst_q == `DMX_W_ADDR) begin
            w_q <= data_q;                                   // [RULE_07]
         end
      end
   end

   // bank select register, upper nibble held at zero
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bsr_q <= `DMX_BSR_RST;
      end else if (qce && phase_q == `DMX_Q4 && op_q == op_load_bank) begin
         bsr_q <= {4'h0, lit_q[3:0]};                        // [RULE_10]
      end
   end

   // negative and zero flags, touched only by the file move
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flag_n_q <= 1'b0;
         flag_z_q <= 1'b0;
      end else if (qce && phase_q == `DMX_Q4 && op_q == op_move_file) begin
         flag_n_q <= data_q[7];                              // [RULE_01]
         flag_z_q <= (data_q == 8'h00);
      end
   end

   // checks
   default clocking dmx_cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence ff_first_end;
      qce && phase_q == `DMX_Q4 && state_q == st_ff_first;
   endsequence
   sequence ff_write_quarter;
      qce && phase_q == `DMX_Q3 && state_q == st_ff_write;
   endsequence

   move_flags_a: assert property ( // [RULE_01]
      (qce && phase_q == `DMX_Q4 && op_q == op_move_file)
      |=> flag_n_q == data_q[7] && flag_z_q == (data_q == 8'h00))
      else $error("file move flags wrong");
   move_dest_w_a: assert property ( // [RULE_02]
      (qce && phase_q == `DMX_Q4 && op_q == op_move_file && !d_q) |=> w_q == $past(data_q))
      else $error("file move did not load working register");
   move_dest_f_a: assert property ( // [RULE_02]
      (qce && phase_q == `DMX_Q3 && op_q == op_move_file && d_q)
      |=> mem_q.wr && mem_q.wdata == $past(data_q) ##[1:8] !mem_q.wr)
      else $error("file move write-back missing");
   bank_addr_a: assert property ( // [RULE_03]
      (take && state_q == st_idle && instr_valid && instr_word[15:10] == `DMX_OPC_MOVE_FILE
       && instr_word[`DMX_A_BIT])
      |=> mem_q.rd && mem_q.addr == {$past(bsr_q[3:0]), $past(instr_word[7:0])})
      else $error("banked address wrong");
   indexed_addr_a: assert property ( // [RULE_04]
      (take && state_q == st_idle && instr_valid && instr_word[15:10] == `DMX_OPC_MOVE_FILE
       && !instr_word[`DMX_A_BIT] && ext_enable && instr_word[7:0] <= `DMX_ILO_MAX)
      |=> mem_q.addr == $past(index_base) + {4'h0, $past(instr_word[7:0])})
      else $error("indexed address wrong");
   ff_no_read_a: assert property ( // [RULE_09]
      ff_first_end |=> (!mem_q.rd && $stable(flag_n_q) && $stable(flag_z_q))[*8])
      else $error("second move cycle read memory or changed flags");
   ff_write_a: assert property ( // [RULE_06]
      (ff_write_quarter ##0 (dst_q != `DMX_W_ADDR))
      |=> mem_q.wr && mem_q.addr == $past(dst_q) && mem_q.wdata == $past(data_q))
      else $error("file-to-file write wrong");
   ff_to_w_a: assert property ( // [RULE_07]
      (qce && phase_q == `DMX_Q4 && state_q == st_ff_write && dst_q == `DMX_W_ADDR)
      |=> w_q == $past(data_q) && !mem_q.wr)
      else $error("file-to-file move into working register wrong");
   bank_nibble_a: assert property ( // [RULE_10]
      (qce && phase_q == `DMX_Q4 && op_q == op_load_bank)
      |=> bsr_q == {4'h0, $past(lit_q[3:0])} && $stable(flag_z_q))
      else $error("bank load wrong");
   load_w_a: assert property ( // [RULE_11]
      (qce && phase_q == `DMX_Q4 && op_q == op_load_w)
      |=> w_q == $past(lit_q) && $stable(flag_n_q) && state_q == st_idle)
      else $error("literal load wrong");
endmodule
`default_nettype wire

// ### logic/dmx_cfg.svh
// Purpose: constants for the data-move decode and execute block
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   included by the execute module
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH

// quarter-phase timing
`define DMX_Q_DIV          3'd2     // clocks per quarter-phase (10 ns at 200 MHz)
`define DMX_Q1             2'h0     // decode
`define DMX_Q2             2'h1     // read
`define DMX_Q3             2'h2     // process
`define DMX_Q4             2'h3     // write

// opcode fields
`define DMX_OPC_MOVE_FILE  6'h14    // 0101 00da, bits 15:10
`define DMX_OPC_LOAD_BANK  8'h01    // 0000 0001, bits 15:8
`define DMX_OPC_LOAD_W     8'h0e    // 0000 1110, bits 15:8
`define DMX_PFX_FF_SRC     4'hc     // first word of file-to-file move
`define DMX_PFX_FF_DST     4'hf     // second word of file-to-file move
`define DMX_D_BIT          9        // destination select bit
`define DMX_A_BIT          8        // access/bank select bit

// addressing
`define DMX_ILO_MAX        8'h5f    // highest indexed / low access offset
`define DMX_ACCESS_HI      4'hf     // page of the upper access bank
`define DMX_W_ADDR         12'hff0  // data-space address of the working register

// reset values
`define DMX_W_RST          8'h00
`define DMX_BSR_RST        8'h00
`endif

// ### logic/dmx_pkg.sv
// Purpose: types shared by the data-move execute block
// Assumes: constants come from dmx_cfg.svh
// Notes:   states and op kinds carry no explicit codes
`default_nettype none
package dmx_pkg;
   // sequencer states
   typedef enum logic [1:0] {st_idle, st_ff_first, st_ff_second, st_ff_write} dmx_state_t;
   // instruction kinds in flight
   typedef enum logic [2:0] {op_none, op_move_file, op_move_ff, op_load_bank,
                             op_load_w} dmx_op_t;
   // data memory request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } dmx_mem_req_t;
endpackage
`default_nettype wire

// ### tb/dmx_mem_model.sv
// Purpose: banked data memory standing beside the data-move block
// Assumes: reads answer combinationally while rd is up
// Notes:   unselected read data shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dmx_mem_model
   import dmx_pkg::*;
(
   // clock
   input  wire logic         clock,
   // request and answer
   input  wire dmx_mem_req_t mem_q,
   output var  logic [7:0]   mem_rdata
);
   logic [7:0] mem [4096];   // whole 4096-byte data space
   logic [7:0] last_q;       // last value shown while selected
   // start from a known image
   initial begin
      last_q = 8'h00;
      for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
   end
   // real data only while rd is up, so a late sample is caught
   always_comb begin
      if (mem_q.rd) begin
         mem_rdata = mem[mem_q.addr];
      end else begin
         mem_rdata = ~last_q;
      end
   end
   // store during the write quarter, remember what was read
   always @(posedge clock) begin
      if (mem_q.wr) begin
         mem[mem_q.addr] <= mem_q.wdata;
      end
      if (mem_q.rd) begin
         last_q <= mem[mem_q.addr];
      end
   end
endmodule
`default_nettype wire

// ### tb/data_move_instruction_exec_tb.sv
// Purpose: self-checking bench for the data-move execute block
// Assumes: decode edge is the last clock of Q1, results land six clocks later
// Notes:   memory image is preset and read back through the model
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_exec_tb
   import dmx_pkg::*;
;
   logic         clock, reset, instr_valid, ext_enable, flag_n_q, flag_z_q;
   logic [15:0]  instr_word;
   logic [11:0]  index_base;
   logic [7:0]   mem_rdata, w_q, bsr_q;
   dmx_mem_req_t mem_q;
   logic [1:0]   phase_q, prev_ph;
   int           err_total, checked, cycles;
   logic [7:0]   w_mdl, bsr_mdl;   // bench model of the working and bank registers
   logic [1:0]   fl_mdl;           // bench model of the N and Z flags

   dmx_exec i_dut (.clock(clock), .reset(reset), .instr_valid(instr_valid),
      .instr_word(instr_word), .ext_enable(ext_enable), .index_base(index_base),
      .mem_rdata(mem_rdata), .mem_q(mem_q), .w_q(w_q), .bsr_q(bsr_q),
      .flag_n_q(flag_n_q), .flag_z_q(flag_z_q), .phase_q(phase_q));
   dmx_mem_model i_mem (.clock(clock), .mem_q(mem_q), .mem_rdata(mem_rdata));

   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      prev_ph <= phase_q;
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // present one word on the first clock of Q1; returns after its decode edge
   task automatic issue(input logic [15:0] word);
      while (!(phase_q === 2'h0 && prev_ph === 2'h3)) clk(1);
      instr_valid = 1'b1;
      instr_word  = word;
      // hold through the second clock of Q1, where the word is taken
      clk(2);
      instr_valid = 1'b0;
   endtask
   // expected data address of a file operand
   function automatic logic [11:0] eaddr(input logic a, input logic [7:0] f, input logic ext);
      if (a) return {bsr_mdl[3:0], f};
      if (f > 8'h5f) return {4'hf, f};
      return ext ? index_base + {4'h0, f} : {4'h0, f};
   endfunction

   // literal loads back to back, flags must stay put
   task automatic t_literals(input logic [7:0] kb, input logic [7:0] kw);
      issue({8'h01, kb});
      issue({8'h0e, kw});
      bsr_mdl = {4'h0, kb[3:0]};
      w_mdl   = kw;
      chk(bsr_q, bsr_mdl);
      clk(6);
      chk(w_q, w_mdl);
      chk({flag_n_q, flag_z_q}, fl_mdl);
   endtask

   // file move over every d, a, ext and both sides of the 5Fh boundary
   task automatic t_move_file();
      logic [11:0] ad;
      logic [7:0]  v, f;
      for (int i = 0; i < 8; i++) begin
         ext_enable = i[2];
         f = (i[0] ^ i[2]) ? 8'h60 : 8'h5f;
         // last value moved is zero, so the flags leave this task as N=0 Z=1
         v = 8'((7 - i) * 8'h35);
         ad = eaddr(i[1], f, i[2]);
         i_mem.mem[ad] = v;
         issue({6'h14, i[0], i[1], f});
         chk(mem_q.rd, 16'h0001);
         chk(mem_q.addr, ad);
         clk(4);
         chk(mem_q.wr, i[0]);
         if (i[0]) chk(mem_q.wdata, v);
         clk(2);
         if (!i[0]) w_mdl = v;
         fl_mdl = {v[7], v == 8'h00};
         chk(w_q, w_mdl);
         chk({flag_n_q, flag_z_q}, fl_mdl);
      end
   endtask

   // two-word move; a wrong second prefix must drop it
   task automatic t_ff(input logic [11:0] src, input logic [11:0] dst, input logic [3:0] pfx);
      logic [7:0] v, old_d;
      v = (src == 12'hff0) ? w_mdl : i_mem.mem[src];
      old_d = (dst == 12'hff0) ? w_mdl : i_mem.mem[dst];
      issue({4'hc, src});
      chk(mem_q.rd, src != 12'hff0);
      if (src != 12'hff0) chk(mem_q.addr, src);
      issue({pfx, dst});
      chk(mem_q.rd, 16'h0000);
      clk(4);
      chk(mem_q.wr, pfx == 4'hf && dst != 12'hff0);
      clk(2);
      chk((dst == 12'hff0) ? w_q : i_mem.mem[dst], (pfx == 4'hf) ? v : old_d);
      chk({flag_n_q, flag_z_q}, fl_mdl);
      if (pfx == 4'hf && dst == 12'hff0) w_mdl = v;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // main sequence; no destination is a program counter or stack byte
   initial begin
      reset = 1'b1;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      ext_enable = 1'b0;
      index_base = 12'hfe0;
      err_total = 0;
      checked = 0;
      cycles = 0;
      w_mdl = 8'h00;
      bsr_mdl = 8'h00;
      fl_mdl = 2'b00;
      repeat (10) @(posedge clock);
      #1 reset = 1'b0;
      t_literals(8'ha7, 8'h5a);
      t_move_file();
      // second pass runs with the Z flag set, so unchanged flags are a real check
      t_literals(8'h3c, 8'hc3);
      i_mem.mem[12'h123] = 8'h81;
      i_mem.mem[12'h0f7] = 8'hc9;
      t_ff(12'h123, 12'hab4, 4'hf);
      t_ff(12'hff0, 12'h3c5, 4'hf);
      t_ff(12'h0f7, 12'hff0, 4'hf);
      t_ff(12'h0f7, 12'hab4, 4'h2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
